// [hw/bimanual_gate.sv]
// Operation
// - Three station inputs exist and two or three of them are made active.
// - Zero, one or two enables are configured and each must be high.
// - Each active station is seen low once after run entry or a re-arm.
// - With all lows seen, release rises when active inputs are all high.
// - Release drops whenever a configured enable input is low.
// - Release drops whenever an active station input is low.
// - A cycle-request edge of the set polarity drops release and re-arms.
`timescale 1ns/100ps
`include "gate_consts.svh"
module bimanual_gate
    import gate_pkg::*;
#(
    parameter int LOGIC_CYCLE_CLKS = `LOGIC_CYCLE_CLKS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire gate_cfg_t cfg,
    input wire gate_in_t pins,
    output logic release_out,
    output logic [2:0] low_pending,
    output logic cycle_edge,
    output gate_state_t state
);

    localparam int TICK_W = $clog2(LOGIC_CYCLE_CLKS + 1);

    logic [TICK_W-1:0] tick_count;
    logic tick;
    logic [`IN_WIDTH-1:0] clean;
    gate_in_t now;
    gate_cfg_t cfg_held;
    logic run_prev;
    logic req_prev;
    logic [2:0] seen_low;
    logic [2:0] next_seen_low;
    logic [2:0] active;
    logic [1:0] en_mask;
    logic stations_high;
    logic enables_high;
    logic edge_hit;
    logic run_entry;
    gate_state_t next_state;

    if (LOGIC_CYCLE_CLKS < 1) begin : g_bad_cycle
        $error("LOGIC_CYCLE_CLKS must be at least one.");
    end
    if ($bits(gate_in_t) != `IN_WIDTH) begin : g_bad_width
        $error("The pin struct does not match the input vector width.");
    end

    // True when every bit of the mask is also set in the value.
    function automatic logic all_set(input logic [2:0] v,
            input logic [2:0] m);
        all_set = (v & m) == m;
    endfunction

    // Stations that take part in the decision.
    function automatic logic [2:0] station_mask(input gate_cfg_t c);
        station_mask = c.three_operators ? 3'h7 : 3'h3;
    endfunction

    // Enable inputs that take part in the decision.
    function automatic logic [1:0] enable_mask(input gate_cfg_t c);
        unique case (c.enable_count)
            2'h0: enable_mask = 2'h0;
            2'h1: enable_mask = 2'h1;
            default: enable_mask = 2'h3;
        endcase
    endfunction

    input_filter #(
        .WIDTH(`IN_WIDTH)
    ) u_filter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .raw(pins),
        .clean(clean)
    );

    assign now = gate_in_t'(clean);

    // Logic execution cycle enable.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tick_count <= '0;
            tick <= 1'h0;
        end else if (tick_count == TICK_W'(LOGIC_CYCLE_CLKS - 1)) begin
            tick_count <= '0;
            tick <= 1'h1;
        end else begin
            tick_count <= tick_count + TICK_W'(1);
            tick <= 1'h0;
        end
    end

    // Configuration is taken only while stopped so it cannot change mid-run.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_held <= '0;
        end else if (tick && state == ST_STOP) begin
            cfg_held <= cfg;
        end
    end

    assign active = station_mask(cfg_held);
    assign en_mask = enable_mask(cfg_held);
    assign stations_high = all_set(now.station, active);
    assign enables_high = all_set({1'h0, now.enable}, {1'h0, en_mask});

    // Previous run sample for run entry detection.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            run_prev <= 1'h0;
        end else if (tick) begin
            run_prev <= now.run;
        end
    end

    // Edges are judged against the last logic-cycle sample.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            req_prev <= 1'h0;
        end else if (tick) begin
            req_prev <= now.cycle_req;
        end
    end

    assign run_entry = now.run && !run_prev;
    assign edge_hit = cfg_held.edge_falling ?
        (req_prev && !now.cycle_req) :
        (!req_prev && now.cycle_req);

    // A low seen in the re-arm cycle still counts: set wins over clear.
    always_comb begin
        next_seen_low = seen_low;
        if (!now.run || run_entry || edge_hit) begin
            next_seen_low = `SEEN_LOW_RESET;
        end
        if (now.run) begin
            next_seen_low = next_seen_low | (~now.station & active);
        end
    end

    // Lows are stored per station so they need not happen together.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seen_low <= `SEEN_LOW_RESET;
        end else if (tick) begin
            seen_low <= next_seen_low;
        end
    end

    // Release never rises on a re-arm cycle, so each station is let go first.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_STOP: begin
                if (now.run) begin
                    next_state = ST_ARM;
                end
            end
            ST_ARM: begin
                if (!now.run) begin
                    next_state = ST_STOP;
                end else if (!edge_hit && !run_entry
                        && all_set(seen_low, active)
                        && stations_high && enables_high) begin
                    next_state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (!now.run) begin
                    next_state = ST_STOP;
                end else if (edge_hit) begin
                    next_state = ST_ARM;
                end else if (!stations_high) begin
                    next_state = ST_ARM;
                end else if (!enables_high) begin
                    next_state = ST_ARM;
                end
            end
            default: next_state = ST_STOP;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= ST_STOP;
        end else if (tick) begin
            state <= next_state;
        end
    end

    // Release is registered so it changes only on a logic-cycle boundary.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            release_out <= `RELEASE_RESET;
        end else if (tick) begin
            release_out <= (next_state == ST_RELEASE);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            low_pending <= 3'h0;
        end else if (tick) begin
            low_pending <= active & ~next_seen_low;
        end
    end

    // One clock wide, so a watcher can count cycle-request edges.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cycle_edge <= 1'h0;
        end else begin
            cycle_edge <= tick && now.run && edge_hit;
        end
    end

endmodule

// [hw/gate_consts.svh]
`ifndef GATE_CONSTS_SVH
`define GATE_CONSTS_SVH

// Clock period of clk_sys in nanoseconds.
`define CLK_PERIOD_NS 40
// Period of the controller logic execution cycle in nanoseconds.
`define LOGIC_CYCLE_NS 4000000
// Clock cycles per logic execution cycle.
`define LOGIC_CYCLE_CLKS (`LOGIC_CYCLE_NS / `CLK_PERIOD_NS)

// Input vector bit positions after synchronisation.
`define IN_STATION_LSB 0
`define IN_ENABLE_LSB 3
`define IN_CYCLE_REQ_POS 5
`define IN_RUN_POS 6
`define IN_WIDTH 7

// Reset values.
`define SEEN_LOW_RESET 3'h0
`define RELEASE_RESET 1'h0

`endif

// [hw/gate_pkg.sv]
package gate_pkg;

    typedef struct packed {
        logic three_operators;
        logic [1:0] enable_count;
        logic edge_falling;
    } gate_cfg_t;

    typedef struct packed {
        logic run;
        logic cycle_req;
        logic [1:0] enable;
        logic [2:0] station;
    } gate_in_t;

    typedef enum logic [2:0] {
        ST_STOP = 3'h1,
        ST_ARM = 3'h2,
        ST_RELEASE = 3'h4
    } gate_state_t;

endpackage

// [hw/input_filter.sv]
`timescale 1ns/100ps
// Three-stage synchroniser; a bit changes once stages two and three agree.
module input_filter #(
    parameter int WIDTH = 7
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] clean
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    if (WIDTH < 1) begin : g_bad_width
        $error("input_filter needs WIDTH of at least one.");
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            clean <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    clean[i] <= stage3[i];
                end
            end
        end
    end

endmodule

// [tb/gate_assertions.sv]
`timescale 1ns/100ps
`include "gate_consts.svh"
module gate_assertions
    import gate_pkg::*;
#(
    parameter int LOGIC_CYCLE_CLKS = `LOGIC_CYCLE_CLKS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire gate_cfg_t cfg,
    input wire gate_in_t pins,
    input wire logic release_out,
    input wire logic [2:0] low_pending,
    input wire logic cycle_edge,
    input wire gate_state_t state
);
    localparam int LAT = LOGIC_CYCLE_CLKS + 6;
    int s0_low;
    int en_low;
    int run_low;
    gate_cfg_t cfg_seen;
    // Follows the configuration the gate holds, taken only while stopped.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_seen <= '0;
        end else if (state == ST_STOP) begin
            cfg_seen <= cfg;
        end
    end
    // Counts how long station 0, enable 0 (when configured) and run have each been held low at the pins.
    always_ff @(posedge clk_sys) begin
        s0_low <= (rst_n && !pins.station[0]) ? s0_low + 1 : 0;
        en_low <= (rst_n && !pins.enable[0]
            && cfg_seen.enable_count != 2'h0) ? en_low + 1 : 0;
        run_low <= (rst_n && !pins.run) ? run_low + 1 : 0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    release_state_a: assert property (
        release_out |-> state == ST_RELEASE)
        else $error("release high outside release state");
    release_armed_a: assert property (
        release_out |-> low_pending == 3'h0)
        else $error("release high with lows pending");
    run_low_a: assert property (
        run_low >= LAT |-> state == ST_STOP)
        else $error("stop not taken after run low");
    station_drop_a: assert property (
        s0_low >= LAT |-> !release_out)
        else $error("release high with station low");
    enable_drop_a: assert property (
        en_low >= LAT |-> !release_out)
        else $error("release high with enable low");
    edge_drop_a: assert property (
        cycle_edge |-> !release_out)
        else $error("release high after cycle edge");
    edge_pulse_a: assert property (
        cycle_edge |=> !cycle_edge)
        else $error("cycle edge longer than one clock");
    rise_armed_a: assert property (
        $rose(release_out) |-> $past(low_pending) == 3'h0 && !cycle_edge)
        else $error("release rose without armed lows");
    cover property ($rose(release_out));
    cover property (cycle_edge);
    cover property (cycle_edge && cfg_seen.edge_falling);
    cover property (en_low >= LAT);
endmodule
bind bimanual_gate gate_assertions #(.LOGIC_CYCLE_CLKS(LOGIC_CYCLE_CLKS))
    u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg), .pins(pins),
    .release_out(release_out), .low_pending(low_pending),
    .cycle_edge(cycle_edge), .state(state));

// [tb/upstream_model.sv]
`timescale 1ns/100ps
module upstream_model
    import gate_pkg::*;
(
    input wire logic [2:0] st,
    input wire logic [1:0] en,
    input wire logic run,
    input wire logic cr,
    output gate_in_t pins
);
    // Pre-evaluated levels only; cycle request is passed through as driven.
    assign pins = gate_in_t'({run, cr, en, st});
endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import gate_pkg::*;
    logic clk_sys;
    logic rst_n;
    gate_cfg_t cfg;
    gate_cfg_t cfg_l;
    gate_in_t pins;
    logic release_out;
    logic [2:0] low_pending;
    gate_state_t state;
    logic [2:0] st;
    logic [1:0] en;
    logic run;
    logic cr;
    logic [2:0] pend;
    logic running;
    logic [5:0] notes[$];
    logic cycle_edge;
    int edges;
    int edges_seen;
    int failures;
    int checked;
    event step_done;
    upstream_model i_up (.st(st), .en(en), .run(run), .cr(cr), .pins(pins));
    bimanual_gate #(.LOGIC_CYCLE_CLKS(4)) i_dut (.clk_sys(clk_sys),
        .rst_n(rst_n), .cfg(cfg), .pins(pins), .release_out(release_out),
        .low_pending(low_pending), .cycle_edge(cycle_edge), .state(state));
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input logic r, input logic [2:0] s,
        input logic [1:0] e, input logic c);
        logic [2:0] am;
        logic [1:0] em;
        logic ed;
        am = cfg_l.three_operators ? 3'h7 : 3'h3;
        em = cfg_l.enable_count[1] ? 2'h3 : {1'h0, cfg_l.enable_count[0]};
        ed = cfg_l.edge_falling ? (cr & !c) : (!cr & c);
        @(negedge clk_sys);
        run = r;
        st = s;
        en = e;
        cr = c;
        if (!r) begin
            pend = 3'h0;
            cfg_l = cfg;
        end else if (!running || ed) begin
            pend = am;
        end
        running = r;
        pend = pend & s;
        repeat (14) @(negedge clk_sys);
        notes.push_back({r, r && ed, r && pend == 3'h0 && (s & am) == am &&
            (e & em) == em, pend});
        ->step_done;
    endtask
    task automatic report_and_stop();
        $display("Checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = !clk_sys;
    end
    initial begin : monitor
        logic [5:0] n;
        edges_seen = 0;
        forever begin
            @(step_done);
            n = notes.pop_front();
            check({release_out, n[5] ? low_pending : 3'h0}, n[3:0]);
            check(4'(state), !n[5] ? 4'(ST_STOP) : n[3] ? 4'(ST_RELEASE) :
                4'(ST_ARM));
            check(4'(edges - edges_seen), {3'h0, n[4]});
            edges_seen = edges;
        end
    end
    always @(negedge clk_sys) begin
        if (cycle_edge === 1'h1) begin
            edges++;
        end
    end
    initial begin
        #250000;
        failures++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'h0;
        {run, st, en, cr, pend, running} = '0;
        cfg = '0;
        cfg_l = '0;
        void'($urandom(86));
        repeat (10) @(negedge clk_sys);
        rst_n = 1'h1;
        for (int k = 0; k < 16; k++) begin
            cfg = gate_cfg_t'(k[3:0]);
            step(0, 3'h7, 2'h3, cr);
            step(1, 3'h7, 2'h3, cr);
            step(1, 3'h5, 2'h3, cr);
            step(1, 3'h2, 2'h3, cr);
            step(1, 3'h7, 2'h3, cr);
            step(1, 3'h7, 2'h2, cr);
            step(1, 3'h7, 2'h1, cr);
            step(1, 3'h7, 2'h3, cr);
            step(1, 3'h7, 2'h3, !cr);
            step(1, 3'h7, 2'h3, !cr);
            for (int j = 0; j < 8; j++) begin
                step(1, $urandom_range(0, 1) ? 3'h7 : 3'($urandom),
                    2'($urandom) | 2'($urandom), 1'($urandom));
            end
            $display("Config %0d done", k);
        end
        report_and_stop();
    end
endmodule
